// file: rcs_top.sv
/*
 * Reset control sequencer: drives the shared open-drain reset line in
 * drive and release-and-test periods, holds master reset, records reset
 * causes and runs the processor reset exception sequence.
 * Assumes one 40 MHz clock, a vector fetch port answering with an ack,
 * and bus cycle status from the bus controller on the same clock.
 */
`default_nettype none
`include "rcs_regs.svh"

// Function
// - Postpone external reset until bus cycle ends or bus timeout expires.
// - Integration unit pins go inactive or high impedance during reset.
// - After external reset released, drive pin low 512 more cycles.
// - Internal reset drives pin at least 512 cycles, longer while requested.
// - After drive, release pin ten cycles, then test; high starts exception.
// - Pin still low at test: drive 512 again and repeat.
// - At power-on hold reset until clock locks plus 512 cycles.
// - Modules reset after clock runs and master reset held four cycles.
// - Reset recognised at bus cycle end; processing in progress aborted.
// - Synchronised reset request asserts internal master reset.
// - Master reset clears trace bits, sets supervisor, mask to seven.
// - Master reset sets the vector table base to zero.
// - Breakpoint input sampled first when master reset negates.
// - Reset vector fetched: stack pointer then program counter.
// - Then first instruction fetched and decoding starts.
// - Cause register keeps one bit per source; several may be set.
// - Cause register updated when reset line tests high after release.
// - General port pins come out of reset as high-impedance inputs.
// - Exception entry address is table base plus vector number offset.
// - Low breakpoint at release sets debug mode flag.
module rcs_top (
   input  wire logic                   clk_in,
   input  wire logic                   sys_rst_in,
   input  wire logic                   ce_in,
   input  wire logic                   external_reset_line_in,
   output logic                        external_reset_line_out,
   output logic                        external_reset_line_oe_n_out,
   input  wire logic [`RCS_INT_W-1:0]  int_reset_req_in,
   input  wire logic                   pll_lock_in,
   input  wire logic                   bus_busy_in,
   input  wire logic                   bus_cycle_end_in,
   input  wire logic [1:0]             breakpoint_request_n_in,
   input  wire logic                   boot_ext_rom_in,
   input  wire logic [31:0]            fetch_data_in,
   input  wire logic                   fetch_ack_in,
   input  wire logic [7:0]             vector_number_in,
   output logic                        master_reset_internal_out,
   output logic                        module_reset_out,
   output logic                        sim_pins_inactive_out,
   output logic                        gp_ports_hiz_out,
   output logic                        abort_out,
   output logic [`RCS_CAUSE_W-1:0]     reset_cause_register_out,
   output logic                        debug_mode_out,
   output rcs_pkg::rcs_status_s        status_out,
   output logic [31:0]                 vector_table_base_out,
   output logic                        fetch_req_out,
   output logic [31:0]                 fetch_addr_out,
   output logic                        boot_rom_select_out,
   output logic [31:0]                 stack_ptr_out,
   output logic [31:0]                 prog_cnt_out,
   output logic                        decode_start_out,
   output logic [15:0]                 opcode_out,
   output logic [31:0]                 exc_entry_addr_out
);

   // Synchronised pin levels
   rcs_pkg::rcs_pins_s pins_s;
   logic [`RCS_SYNC_W-1:0] sync_raw;

   // Sequencer state
   rcs_pkg::rcs_state_e         state_q;
   rcs_pkg::rcs_state_e         state_d;
   logic [`RCS_CNT_W-1:0]       cnt_q;
   logic [`RCS_CNT_W-1:0]       cnt_d;
   logic [`RCS_CAUSE_W-1:0]     pend_q;
   logic [`RCS_CAUSE_W-1:0]     pend_d;
   logic [`RCS_CAUSE_W-1:0]     cause_q;
   logic [`RCS_CAUSE_W-1:0]     cause_d;
   logic                        mrst_q;
   logic                        mrst_d;
   logic [2:0]                  mcnt_q;
   logic [2:0]                  mcnt_d;
   logic                        modrst_q;
   logic                        modrst_d;
   logic                        oe_n_q;
   logic                        oe_n_d;
   logic                        abort_q;
   logic                        abort_d;

   // Processor reset state
   rcs_pkg::rcs_status_s        stat_q;
   rcs_pkg::rcs_status_s        stat_d;
   logic [31:0]                 vbr_q;
   logic [31:0]                 vbr_d;
   logic                        dbg_q;
   logic                        dbg_d;
   logic                        freq_q;
   logic                        freq_d;
   logic [31:0]                 faddr_q;
   logic [31:0]                 faddr_d;
   logic                        brom_q;
   logic                        brom_d;
   logic [31:0]                 isp_q;
   logic [31:0]                 isp_d;
   logic [31:0]                 pc_q;
   logic [31:0]                 pc_d;
   logic                        dec_q;
   logic                        dec_d;
   logic [15:0]                 op_q;
   logic [15:0]                 op_d;
   logic [31:0]                 exc_q;
   logic [31:0]                 exc_d;

   // Request decode helpers
   logic                        ext_low;
   logic                        int_any;
   logic [`RCS_CAUSE_W-1:0]     new_cause;

   rcs_sync #(
      .W       (`RCS_SYNC_W),
      .RST_VAL (`RCS_SYNC_RST)
   ) u_sync (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .ce_in      (ce_in),
      .async_in   ({pll_lock_in, breakpoint_request_n_in,
                    external_reset_line_in}),
      .sync_out   (sync_raw)
   );

   // Request sources after synchronisation
   always_comb begin
      pins_s  = rcs_pkg::rcs_pins_s'(sync_raw);
      ext_low = ~pins_s.pin;
      int_any = |int_reset_req_in;
      new_cause = '0;
      new_cause[`RCS_CAUSE_INT_LO +: `RCS_INT_W] = int_reset_req_in;
   end

   // Sequencer next state, counters and cause bookkeeping
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + 10'd1;
      pend_d  = pend_q;
      cause_d = cause_q;
      abort_d = 1'b0;
      // every active internal source leaves its bit
      pend_d  = pend_q | new_cause;
      case (state_q)
         rcs_pkg::ST_POR: begin
            pend_d[`RCS_CAUSE_POR] = 1'b1;
            if (pins_s.pll_lock) begin
               state_d = rcs_pkg::ST_DRIVE;
               cnt_d   = '0;
            end
         end
         rcs_pkg::ST_DEFER: begin
            // wait for bus cycle end or timeout
            if (bus_cycle_end_in || !bus_busy_in ||
                cnt_q == `RCS_BUS_TMO - 10'd1) begin
               abort_d = 1'b1;
               cnt_d   = '0;
               if (pend_q[`RCS_CAUSE_EXT] && ext_low)
                  state_d = rcs_pkg::ST_EXTHOLD;
               else
                  state_d = rcs_pkg::ST_DRIVE;
            end
         end
         rcs_pkg::ST_EXTHOLD: begin
            // drive starts once outside party lets go
            cnt_d = '0;
            if (!ext_low)
               state_d = rcs_pkg::ST_DRIVE;
         end
         rcs_pkg::ST_DRIVE: begin
            if (cnt_q >= `RCS_DRIVE_CYC - 10'd1) begin
               cnt_d = cnt_q;
               if (!int_any) begin
                  state_d = rcs_pkg::ST_RELEASE;
                  cnt_d   = '0;
               end
            end
         end
         rcs_pkg::ST_RELEASE: begin
            // test pin after ten released cycles
            if (cnt_q == `RCS_RELEASE_CYC - 10'd1) begin
               cnt_d = '0;
               if (ext_low) begin
                  state_d = rcs_pkg::ST_DRIVE;
               end else begin
                  state_d = rcs_pkg::ST_BREAKPOINT_REQUEST;
                  cause_d = pend_q;
                  pend_d  = new_cause;
               end
            end
         end
         rcs_pkg::ST_RUN, rcs_pkg::ST_BREAKPOINT_REQUEST, rcs_pkg::ST_FET_SP,
         rcs_pkg::ST_FET_PC, rcs_pkg::ST_FET_OP, rcs_pkg::ST_EXEC: begin
            cnt_d = '0;
            if (ext_low || int_any) begin
               state_d = rcs_pkg::ST_DEFER;
               pend_d[`RCS_CAUSE_EXT] = pend_q[`RCS_CAUSE_EXT] | ext_low;
            end else begin
               case (state_q)
                  rcs_pkg::ST_BREAKPOINT_REQUEST:   state_d = rcs_pkg::ST_FET_SP;
                  rcs_pkg::ST_FET_SP:
                     if (fetch_ack_in) state_d = rcs_pkg::ST_FET_PC;
                  rcs_pkg::ST_FET_PC:
                     if (fetch_ack_in) state_d = rcs_pkg::ST_FET_OP;
                  rcs_pkg::ST_FET_OP:
                     if (fetch_ack_in) state_d = rcs_pkg::ST_EXEC;
                  rcs_pkg::ST_EXEC:   state_d = rcs_pkg::ST_RUN;
                  default:            state_d = state_q;
               endcase
            end
         end
         default: begin
            state_d = rcs_pkg::ST_POR;
            cnt_d   = '0;
         end
      endcase
   end

   // Pin drive, master and module reset
   always_comb begin
      mrst_d = (state_d == rcs_pkg::ST_POR)     ||
               (state_d == rcs_pkg::ST_EXTHOLD) ||
               (state_d == rcs_pkg::ST_DRIVE)   ||
               (state_d == rcs_pkg::ST_RELEASE);
      // enable pull-down only, low while driving
      oe_n_d = !((state_d == rcs_pkg::ST_POR) ||
                 (state_d == rcs_pkg::ST_DRIVE));
      if (!mrst_q)
         mcnt_d = '0;
      else if (mcnt_q < `RCS_MRST_MIN - 3'd1)
         mcnt_d = mcnt_q + 3'd1;
      else
         mcnt_d = mcnt_q;
      modrst_d = mrst_q && pins_s.pll_lock &&
                 (mcnt_q >= `RCS_MRST_MIN - 3'd1);
   end

   // Processor reset exception sequence
   always_comb begin
      stat_d  = stat_q;
      vbr_d   = vbr_q;
      dbg_d   = dbg_q;
      freq_d  = 1'b0;
      faddr_d = faddr_q;
      brom_d  = 1'b0;
      isp_d   = isp_q;
      pc_d    = pc_q;
      dec_d   = 1'b0;
      op_d    = op_q;
      if (mrst_d) begin
         stat_d.trace      = `RCS_TRACE_RST;
         stat_d.supervisor = `RCS_SUPER_RST;
         stat_d.ipm        = `RCS_IPM_RST;
         vbr_d = `RCS_VBR_RST;
      end
      if (state_q == rcs_pkg::ST_BREAKPOINT_REQUEST)
         dbg_d = ~&pins_s.breakpoint_request_n;
      if (state_d == rcs_pkg::ST_FET_SP) begin
         freq_d  = 1'b1;
         faddr_d = vbr_q + `RCS_VEC_SP_OFF;
         brom_d  = boot_ext_rom_in;
      end
      if (state_d == rcs_pkg::ST_FET_PC) begin
         freq_d  = 1'b1;
         faddr_d = vbr_q + `RCS_VEC_PC_OFF;
         brom_d  = boot_ext_rom_in;
      end
      if (state_d == rcs_pkg::ST_FET_OP) begin
         freq_d  = 1'b1;
         faddr_d = (state_q == rcs_pkg::ST_FET_PC) ? fetch_data_in : pc_q;
         brom_d  = boot_ext_rom_in;
      end
      if (fetch_ack_in && state_q == rcs_pkg::ST_FET_SP)
         isp_d = fetch_data_in;
      if (fetch_ack_in && state_q == rcs_pkg::ST_FET_PC)
         pc_d = fetch_data_in;
      if (fetch_ack_in && state_q == rcs_pkg::ST_FET_OP &&
          state_d == rcs_pkg::ST_EXEC) begin
         op_d  = fetch_data_in[15:0];
         dec_d = 1'b1;
      end
      exc_d = vbr_q + {22'h000000, vector_number_in, 2'h0};
   end

   // Sequencer registers
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q  <= rcs_pkg::ST_POR;
         cnt_q    <= '0;
         pend_q   <= '0;
         cause_q  <= '0;
         mrst_q   <= 1'b1;
         mcnt_q   <= '0;
         modrst_q <= 1'b0;
         oe_n_q   <= 1'b0;
         abort_q  <= 1'b0;
      end else if (ce_in) begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         pend_q   <= pend_d;
         cause_q  <= cause_d;
         mrst_q   <= mrst_d;
         mcnt_q   <= mcnt_d;
         modrst_q <= modrst_d;
         oe_n_q   <= oe_n_d;
         abort_q  <= abort_d;
      end
   end

   // Processor state registers
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         stat_q  <= '{trace: `RCS_TRACE_RST, supervisor: `RCS_SUPER_RST,
                      ipm: `RCS_IPM_RST};
         vbr_q   <= `RCS_VBR_RST;
         dbg_q   <= 1'b0;
         freq_q  <= 1'b0;
         faddr_q <= '0;
         brom_q  <= 1'b0;
         isp_q   <= '0;
         pc_q    <= '0;
         dec_q   <= 1'b0;
         op_q    <= '0;
         exc_q   <= '0;
      end else if (ce_in) begin
         stat_q  <= stat_d;
         vbr_q   <= vbr_d;
         dbg_q   <= dbg_d;
         freq_q  <= freq_d;
         faddr_q <= faddr_d;
         brom_q  <= brom_d;
         isp_q   <= isp_d;
         pc_q    <= pc_d;
         dec_q   <= dec_d;
         op_q    <= op_d;
         exc_q   <= exc_d;
      end
   end

   // Outputs; the pin data is a constant low, only the enable toggles
   assign external_reset_line_out      = 1'b0;
   assign external_reset_line_oe_n_out = oe_n_q;
   assign master_reset_internal_out    = mrst_q;
   assign module_reset_out             = modrst_q;
   assign sim_pins_inactive_out        = mrst_q;
   assign gp_ports_hiz_out             = mrst_q;
   assign abort_out                    = abort_q;
   assign reset_cause_register_out     = cause_q;
   assign debug_mode_out               = dbg_q;
   assign status_out                   = stat_q;
   assign vector_table_base_out        = vbr_q;
   assign fetch_req_out                = freq_q;
   assign fetch_addr_out               = faddr_q;
   assign boot_rom_select_out          = brom_q;
   assign stack_ptr_out                = isp_q;
   assign prog_cnt_out                 = pc_q;
   assign decode_start_out             = dec_q;
   assign opcode_out                   = op_q;
   assign exc_entry_addr_out           = exc_q;

endmodule

`default_nettype wire

// file: rcs_regs.svh
/*
 * Constants of the reset control sequencer: cycle counts, reset values,
 * field positions of the reset cause register and vector offsets.
 * Assumes inclusion by bare name from the sequencer sources.
 */
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// Counter width, wide enough for the longest drive period
`define RCS_CNT_W          10
// Cycles of one pin drive period
`define RCS_DRIVE_CYC      10'd512
// Cycles of the release-and-test window
`define RCS_RELEASE_CYC    10'd10
// Least cycles of master reset before modules reset
`define RCS_MRST_MIN       3'd4
// Longest wait for the bus cycle in progress to end
`define RCS_BUS_TMO        10'd64

// Reset cause register layout
`define RCS_CAUSE_W        5
`define RCS_CAUSE_EXT      0
`define RCS_CAUSE_POR      1
`define RCS_CAUSE_INT_LO   2
`define RCS_INT_W          3

// Processor state after master reset
`define RCS_IPM_RST        3'h7
`define RCS_TRACE_RST      2'h0
`define RCS_SUPER_RST      1'h1
`define RCS_VBR_RST        32'h00000000

// Reset vector layout relative to the table base
`define RCS_VEC_SP_OFF     32'h00000000
`define RCS_VEC_PC_OFF     32'h00000004
`define RCS_VEC_SHIFT      2

// Synchroniser idle levels: pll lock, breakpoints, reset pin
// Lock idles low so no false lock appears right after reset
`define RCS_SYNC_W         4
`define RCS_SYNC_RST       4'h6

`endif

// file: rcs_pkg.sv
/*
 * Types of the reset control sequencer: sequencer states and the
 * processor status fields that master reset initialises.
 * Assumes rcs_regs.svh for widths.
 */
`default_nettype none
`include "rcs_regs.svh"

package rcs_pkg;

   // Sequencer states, one-hot
   typedef enum logic [10:0] {
      ST_POR     = 11'h001,
      ST_RUN     = 11'h002,
      ST_DEFER   = 11'h004,
      ST_EXTHOLD = 11'h008,
      ST_DRIVE   = 11'h010,
      ST_RELEASE = 11'h020,
      ST_BREAKPOINT_REQUEST    = 11'h040,
      ST_FET_SP  = 11'h080,
      ST_FET_PC  = 11'h100,
      ST_FET_OP  = 11'h200,
      ST_EXEC    = 11'h400
   } rcs_state_e;

   // Processor status fields set by master reset
   typedef struct packed {
      logic [1:0] trace;
      logic       supervisor;
      logic [2:0] ipm;
   } rcs_status_s;

   // Synchronised pin levels
   typedef struct packed {
      logic       pll_lock;
      logic [1:0] breakpoint_request_n;
      logic       pin;
   } rcs_pins_s;

endpackage

`default_nettype wire

// file: rcs_sync.sv
/*
 * Two-stage synchroniser for a group of levels.
 * Assumes inputs come from outside the clk_in domain.
 */
`default_nettype none

module rcs_sync #(
   parameter int          W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // Next values: first stage feeds only the second
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Two flops, frozen while the clock enable is low
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else if (ce_in) begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule

`default_nettype wire

// file: rcs_top_monitor.sv
/*
 * Checker of the reset control sequencer port behaviour.
 * Assumes it is bound to rcs_top and sees one clock domain.
 */
`default_nettype none
`include "rcs_regs.svh"

module rcs_top_monitor (
   input wire logic                    clk_in,
   input wire logic                    sys_rst_in,
   input wire logic                    ce_in,
   input wire logic                    external_reset_line_out,
   input wire logic                    external_reset_line_oe_n_out,
   input wire logic                    fetch_ack_in,
   input wire logic [7:0]              vector_number_in,
   input wire logic                    master_reset_internal_out,
   input wire logic                    module_reset_out,
   input wire logic                    sim_pins_inactive_out,
   input wire logic                    gp_ports_hiz_out,
   input wire logic                    abort_out,
   input wire logic [`RCS_CAUSE_W-1:0] reset_cause_register_out,
   input wire rcs_pkg::rcs_status_s    status_out,
   input wire logic [31:0]             vector_table_base_out,
   input wire logic                    fetch_req_out,
   input wire logic [31:0]             fetch_addr_out,
   input wire logic                    decode_start_out,
   input wire logic [31:0]             exc_entry_addr_out
);
   logic [10:0] lo_q, lo_d;
   logic [4:0]  hi_q, hi_d;
   logic        rst_q, rst_d;

   // Run lengths of pin drive and release, saturating
   always_comb begin
      lo_d = external_reset_line_oe_n_out ? 11'h0 : lo_q + {10'h0, ~&lo_q};
      hi_d = external_reset_line_oe_n_out ? hi_q + {4'h0, ~&hi_q} : 5'h0;
      rst_d = sys_rst_in;
   end

   // Counter registers
   always_ff @(posedge clk_in) begin
      lo_q  <= sys_rst_in ? 11'h0 : lo_d;
      hi_q  <= sys_rst_in ? 5'h0 : hi_d;
      rst_q <= rst_d;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   AST_PIN_NEVER_HIGH: assert property (
      external_reset_line_out == 1'b0) else $error("pin data not low");
   AST_DRIVE_512: assert property (
      $rose(external_reset_line_oe_n_out) && master_reset_internal_out
      |-> lo_q >= 11'd512) else $error("drive period short");
   AST_RELEASE_TEN: assert property (
      $fell(master_reset_internal_out) |-> hi_q == 5'd10)
      else $error("release window not ten");
   AST_MODULE_RESET: assert property (
      $rose(module_reset_out) |-> $past(master_reset_internal_out, 4)
      && master_reset_internal_out) else $error("module reset early");
   AST_ABORT_AT_MRST: assert property (
      abort_out |-> $rose(master_reset_internal_out) ##1 !abort_out)
      else $error("abort not with master reset");
   AST_STATUS_INIT: assert property (
      master_reset_internal_out && $past(master_reset_internal_out)
      |-> status_out == 6'b001111 && vector_table_base_out == 32'h0)
      else $error("processor state not initialised");
   AST_PINS_QUIET: assert property (
      sim_pins_inactive_out == master_reset_internal_out
      && gp_ports_hiz_out == master_reset_internal_out)
      else $error("pins not quiet in reset");
   AST_CAUSE_HELD: assert property (
      master_reset_internal_out && $past(master_reset_internal_out)
      |-> $stable(reset_cause_register_out)) else $error("cause moved");
   AST_FIRST_FETCH: assert property (
      $fell(master_reset_internal_out) |-> ##[0:2] fetch_req_out
      && fetch_addr_out == vector_table_base_out)
      else $error("stack fetch missing");
   AST_FETCH_HOLD: assert property (
      fetch_req_out && !fetch_ack_in |=> fetch_req_out
      && $stable(fetch_addr_out)) else $error("fetch request dropped");
   AST_ENTRY_ADDR: assert property (
      !rst_q && $past(ce_in)
      |-> exc_entry_addr_out == $past(vector_table_base_out)
      + {22'h0, $past(vector_number_in), 2'b00})
      else $error("entry address wrong");

   // Main scenarios reached
   cover property ($fell(master_reset_internal_out));
   cover property (abort_out);
   cover property (decode_start_out);
endmodule

bind rcs_top rcs_top_monitor u_mon (.*);

`default_nettype wire

// file: rcs_line_model.sv
/*
 * Outside party on the shared open-drain reset line with pull-up.
 * Assumes the bench says when the party holds the line low.
 */
`default_nettype none

module rcs_line_model (
   input  wire logic oe_n_in,
   input  wire logic hold_in,
   output logic      line_out
);
   assign line_out = (!oe_n_in || hold_in) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// file: rcs_top_tb_top.sv
/*
 * Testbench of the reset control sequencer: power-on, internal and
 * external resets, vector fetches. Assumes rcs_top and rcs_line_model.
 */
`default_nettype none

module rcs_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in, sys_rst_in, hold, lock, busy, bend, ack, bootx;
   logic        oe_n, mrst, dbg, freq, bsel, dstart, line, ce;
   logic [2:0]  ireq;
   logic [1:0]  breakpoint_request_n;
   logic [7:0]  vnum;
   logic [4:0]  cause;
   logic [15:0] opc;
   logic [31:0] fdata, vector_table_base, faddr, sp, pc, entry;
   rcs_pkg::rcs_status_s status;
   int          err_total, n_tests, cyc, t0, n_lo;

   rcs_line_model line_m (.oe_n_in(oe_n), .hold_in(hold), .line_out(line));
   rcs_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
      .external_reset_line_in(line), .external_reset_line_out(),
      .external_reset_line_oe_n_out(oe_n), .int_reset_req_in(ireq),
      .pll_lock_in(lock), .bus_busy_in(busy), .bus_cycle_end_in(bend),
      .breakpoint_request_n_in(breakpoint_request_n), .boot_ext_rom_in(bootx),
      .fetch_data_in(fdata), .fetch_ack_in(ack), .vector_number_in(vnum),
      .master_reset_internal_out(mrst), .module_reset_out(),
      .sim_pins_inactive_out(), .gp_ports_hiz_out(), .abort_out(),
      .reset_cause_register_out(cause), .debug_mode_out(dbg),
      .status_out(status), .vector_table_base_out(vector_table_base),
      .fetch_req_out(freq), .fetch_addr_out(faddr),
      .boot_rom_select_out(bsel), .stack_ptr_out(sp), .prog_cnt_out(pc),
      .decode_start_out(dstart), .opcode_out(opc),
      .exc_entry_addr_out(entry));

   // Clock, 25 ns period
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic test_done;
      $display("Checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Wait on master reset level, sampled at falling edges
   task automatic wait_mrst(input logic v, input int lim);
      int i;
      i = 0;
      while (mrst !== v && i < lim) begin
         @(negedge clk_in);
         i++;
      end
      check("master reset", {31'h0, v}, {31'h0, mrst});
   endtask

   // One vector or opcode fetch answered with a one-cycle ack
   task automatic fetch(input logic [31:0] addr, data);
      int i;
      i = 0;
      while (freq !== 1'b1 && i < 20) begin
         @(negedge clk_in);
         i++;
      end
      check("fetch addr", addr, faddr);
      check("boot select", {31'h0, bootx}, {31'h0, bsel});
      @(posedge clk_in);
      ack <= 1'b1;
      fdata <= data;
      @(posedge clk_in);
      ack <= 1'b0;
      fdata <= ~data;
      @(negedge clk_in);
   endtask

   // Reset exception sequence after release
   task automatic boot(input logic dbg_exp);
      int i;
      check("status", 32'h0f, {26'h0, status});
      fetch(32'h0, 32'h0000_1ff0);
      fetch(32'h4, 32'h0000_0400);
      fetch(32'h400, 32'h0000_4e71);
      i = 0;
      while (dstart !== 1'b1 && i < 4) begin
         @(negedge clk_in);
         i++;
      end
      check("decode start", 32'h1, {31'h0, dstart});
      check("stack ptr", 32'h0000_1ff0, sp);
      check("prog cnt", 32'h0000_0400, pc);
      check("opcode", 32'h4e71, {16'h0, opc});
      check("debug flag", {31'h0, dbg_exp}, {31'h0, dbg});
   endtask

   // Cycle count and hang limit
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 9000) begin
         err_total++;
         test_done;
      end
   end

   initial begin
      {hold, lock, busy, bend, ack, bootx, ireq, vnum} = '0;
      breakpoint_request_n = 2'b11;
      ce = 1'b1;
      fdata = 32'h0;
      cyc = 0;
      sys_rst_in = 1'b1;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (40) @(negedge clk_in);
      check("pin held", 32'h0, {31'h0, oe_n});
      check("vector base", 32'h0, vector_table_base);
      @(posedge clk_in);
      lock <= 1'b1;
      t0 = cyc;
      wait_mrst(1'b0, 700);
      check("lock hold", 32'h1, {31'h0, (cyc - t0) >= 522});
      check("cause", 32'h02, {27'h0, cause});
      boot(1'b0);
      // Two internal sources while a bus cycle runs
      @(posedge clk_in);
      busy <= 1'b1;
      ireq <= 3'b101;
      bootx <= 1'b1;
      repeat (20) @(negedge clk_in);
      check("deferred", 32'h1, {31'h0, mrst === 1'b0});
      @(posedge clk_in);
      bend <= 1'b1;
      @(posedge clk_in);
      bend <= 1'b0;
      busy <= 1'b0;
      wait_mrst(1'b1, 4);
      repeat (600) @(negedge clk_in);
      check("long drive", 32'h0, {31'h0, oe_n});
      @(posedge clk_in);
      ireq <= 3'b000;
      breakpoint_request_n <= 2'b10;
      wait_mrst(1'b0, 600);
      check("cause", 32'h14, {27'h0, cause});
      boot(1'b1);
      // Outside party holds the line, then again in the test window
      @(posedge clk_in);
      hold <= 1'b1;
      breakpoint_request_n <= 2'b11;
      bootx <= 1'b0;
      t0 = cyc;
      wait_mrst(1'b1, 80);
      repeat (50) @(negedge clk_in);
      check("not driven", 32'h1, {31'h0, oe_n});
      @(posedge clk_in);
      hold <= 1'b0;
      n_lo = 0;
      while (oe_n !== 1'b0 && n_lo < 20) begin
         @(negedge clk_in);
         n_lo++;
      end
      n_lo = 0;
      while (oe_n === 1'b0 && n_lo < 2000) begin
         @(negedge clk_in);
         n_lo++;
      end
      check("ext drive", 32'd512, n_lo);
      @(posedge clk_in);
      hold <= 1'b1;
      repeat (12) @(posedge clk_in);
      hold <= 1'b0;
      wait_mrst(1'b0, 700);
      check("retest", 32'h1, {31'h0, (cyc - t0) >= 1100});
      check("cause", 32'h01, {27'h0, cause});
      boot(1'b0);
      @(posedge clk_in);
      vnum <= 8'h40;
      repeat (3) @(negedge clk_in);
      check("entry", 32'h100, entry);
      // Clock enable low freezes the entry address register
      @(posedge clk_in);
      ce <= 1'b0;
      vnum <= 8'h10;
      repeat (3) @(negedge clk_in);
      check("frozen entry", 32'h100, entry);
      @(posedge clk_in);
      ce <= 1'b1;
      repeat (3) @(negedge clk_in);
      check("entry", 32'h40, entry);
      test_done;
   end
endmodule

`default_nettype wire
